// ### src/dllm_dll_mode.sv
// How it works
// (R1) Controller idles device before self refresh
// (R2) Controller changes clock only inside self refresh
// (R3) Controller holds CKE high until lock
// (R4) Exit delay chosen by abort bit; enable DLL
// (R5) MR0 reset bit starts DLL reset
// (R6) Controller reprograms latencies after reset
// (R7) New commands wait update, lock, calibration
// (R8) DLL disabled while enable bit is zero
// (R9) Controller limits clock in DLL-off mode
// (R10) DLL-off supports read ten, write nine only
// (R11) No parity while DLL is off
// (R12) DLL-off strobe window starts one earlier
// (R13) Clock stable outside self refresh
// (R14) Clock ignored after self refresh entry hold
// (R15) Parity latency disabled around clock change
// (R16) Extra-clock settings written before leaving idle
// (R17) Lock value before entry relocks at exit
// (R18) Below minimum frequency use DLL-off sequence
// (R19) Spread spectrum within range and rate
// (R20) Band one percent only after relock
// (R21) Drift outside band needs DLL reset
// (R22) DLL off by clearing enable bit
// (R23) All timings are programmable cycle counts
`timescale 1ns/10ps
module dllm_dll_mode
    import dllm_pkg::*;
(
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link clock and decoded command
    input wire logic linkClk,
    input wire logic cmdValid,
    input wire dllm_pkg::dllm_cmd_type cmdCode,
    input wire logic [2:0] mrIndex,
    input wire logic [dllm_pkg::DLLM_MR_W-1:0] mrValue,
    // Latency configuration
    input wire logic [dllm_pkg::DLLM_LAT_W-1:0] readLatency,
    input wire logic [dllm_pkg::DLLM_LAT_W-1:0] writeLatency,
    input wire logic [dllm_pkg::DLLM_LAT_W-1:0] additiveLatency,
    // Timing counts in core cycles
    input wire logic [dllm_pkg::DLLM_TIMER_W-1:0] srEntryClockHold,
    input wire logic [dllm_pkg::DLLM_TIMER_W-1:0] srExitDelay,
    input wire logic [dllm_pkg::DLLM_TIMER_W-1:0] srExitAbortDelay,
    input wire logic [dllm_pkg::DLLM_TIMER_W-1:0] modeUpdateDelay,
    input wire logic [dllm_pkg::DLLM_TIMER_W-1:0] dllLockTime,
    input wire logic [dllm_pkg::DLLM_TIMER_W-1:0] longCalibrationTime,
    // Error flag clear
    input wire logic errClear,
    // Status
    output logic dllEnabled,
    output logic dllLocked,
    output logic inSelfRefresh,
    output logic clockIgnored,
    output logic cmdReady,
    output logic lockedCmdReady,
    output logic [dllm_pkg::DLLM_LAT_W:0] strobeStartCycles,
    output logic latencyUnsupported,
    output logic parityViolation,
    output logic sequenceViolation
);
    import dllm_pkg::*;

    // Link domain: capture command into holding words
    logic linkRst;
    logic linkToggle_reg;
    dllm_cmd_type linkCmd_reg;
    logic [2:0] linkIdx_reg;
    logic [DLLM_MR_W-1:0] linkVal_reg;
    logic linkTake;

    dllm_sync u_linkRstSync (
        .clk(linkClk),
        .rst(1'b0),
        .asyncIn(rst),
        .syncOut(linkRst)
    );

    assign linkTake = cmdValid && (cmdCode != DLLM_CMD_NOP);

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            linkToggle_reg <= 1'b0;
            linkCmd_reg <= DLLM_CMD_NOP;
            linkIdx_reg <= 3'h0;
            linkVal_reg <= '0;
        end else if (linkTake) begin
            linkToggle_reg <= ~linkToggle_reg;
            linkCmd_reg <= cmdCode;
            linkIdx_reg <= mrIndex;
            linkVal_reg <= mrValue;
        end
    end

    // Core domain: event from toggle, words read only once stable
    logic coreToggle;
    logic toggleSeen_reg;
    logic cmdEvent;

    dllm_sync u_toggleSync (
        .clk(ref_clk),
        .rst(rst),
        .asyncIn(linkToggle_reg),
        .syncOut(coreToggle)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            toggleSeen_reg <= 1'b0;
        end else begin
            toggleSeen_reg <= coreToggle;
        end
    end

    assign cmdEvent = coreToggle ^ toggleSeen_reg;

    // Command decode
    wire isMrs = cmdEvent && (linkCmd_reg == DLLM_CMD_MRS);
    wire isSre = cmdEvent && (linkCmd_reg == DLLM_CMD_SRE);
    wire isSrx = cmdEvent && (linkCmd_reg == DLLM_CMD_SRX);
    wire isZq = cmdEvent && (linkCmd_reg == DLLM_CMD_ZQCL);
    wire isOther = cmdEvent && !isMrs && !isSre && !isSrx && !isZq;
    wire mr0Write = isMrs && (linkIdx_reg == DLLM_MR0);
    wire mr1Write = isMrs && (linkIdx_reg == DLLM_MR1);
    wire mr4Write = isMrs && (linkIdx_reg == DLLM_MR4);
    wire mr5Write = isMrs && (linkIdx_reg == DLLM_MR5);
    wire mr6Write = isMrs && (linkIdx_reg == DLLM_MR6);
    wire newEnable = linkVal_reg[DLLM_MR1_DLL_ENABLE_BIT];
    wire resetReq = linkVal_reg[DLLM_MR0_DLL_RESET_BIT];

    // Mode state
    logic dllEnable_reg;
    logic srAbort_reg;
    logic [2:0] parityLat_reg;
    logic inSr_reg;
    logic relockAtExit_reg;
    dllm_dll_type dll_reg;
    dllm_dll_type dll_next;

    // Timers
    logic modBusy;
    logic lockBusy;
    logic srBusy;
    logic zqBusy;
    logic startLock;
    logic [DLLM_TIMER_W-1:0] exitCycles;

    assign exitCycles = srAbort_reg ? srExitAbortDelay : srExitDelay; // [R4]

    dllm_timer #(.WIDTH(DLLM_TIMER_W)) u_modTimer (
        .clk(ref_clk),
        .rst(rst),
        .start(isMrs),
        .cycles(modeUpdateDelay), // [R23]
        .busy(modBusy)
    );

    dllm_timer #(.WIDTH(DLLM_TIMER_W)) u_lockTimer (
        .clk(ref_clk),
        .rst(rst),
        .start(startLock),
        .cycles(dllLockTime), // [R23]
        .busy(lockBusy)
    );

    // Self refresh timer serves entry hold and exit delay in turn
    dllm_timer #(.WIDTH(DLLM_TIMER_W)) u_srTimer (
        .clk(ref_clk),
        .rst(rst),
        .start(isSre || isSrx),
        .cycles(isSre ? srEntryClockHold : exitCycles), // [R14] [R4]
        .busy(srBusy)
    );

    dllm_timer #(.WIDTH(DLLM_TIMER_W)) u_zqTimer (
        .clk(ref_clk),
        .rst(rst),
        .start(isZq),
        .cycles(longCalibrationTime), // [R7]
        .busy(zqBusy)
    );

    // Lock starts on reset request, or by itself at exit after an early MR6
    wire resetStart = mr0Write && resetReq && dllEnable_reg && !inSr_reg; // [R5]
    wire autoRelock = isSrx && relockAtExit_reg && dllEnable_reg; // [R17]
    assign startLock = resetStart || autoRelock;

    always_comb begin
        dll_next = dll_reg;
        case (dll_reg)
            DLLM_DLL_OFF: begin
                if (mr1Write && newEnable) begin
                    dll_next = DLLM_DLL_WAIT_RESET;
                end
            end
            DLLM_DLL_WAIT_RESET: begin
                if (startLock) begin
                    dll_next = DLLM_DLL_LOCKING;
                end
            end
            DLLM_DLL_LOCKING: begin
                if (!lockBusy && !startLock) begin
                    dll_next = DLLM_DLL_LOCKED; // [R7]
                end
            end
            DLLM_DLL_LOCKED: begin
                if (startLock) begin
                    dll_next = DLLM_DLL_LOCKING; // [R21]
                end
            end
            default: begin
                dll_next = DLLM_DLL_OFF;
            end
        endcase
        // Clearing the enable bit wins over everything
        if (mr1Write && !newEnable) begin
            dll_next = DLLM_DLL_OFF; // [R8] [R22]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dll_reg <= DLLM_DLL_WAIT_RESET;
            dllEnable_reg <= DLLM_DLL_ENABLE_RESET;
            srAbort_reg <= DLLM_SR_ABORT_RESET;
            parityLat_reg <= DLLM_PARITY_RESET;
            inSr_reg <= 1'b0;
            relockAtExit_reg <= 1'b0;
        end else begin
            dll_reg <= dll_next;
            if (mr1Write) begin
                dllEnable_reg <= newEnable; // [R8]
            end
            if (mr4Write) begin
                srAbort_reg <= linkVal_reg[DLLM_MR4_SR_ABORT_BIT];
            end
            if (mr5Write) begin
                parityLat_reg <= linkVal_reg[DLLM_MR5_PARITY_MSB:DLLM_MR5_PARITY_LSB]; // [R15]
            end
            if (isSre) begin
                inSr_reg <= 1'b1;
            end else if (isSrx) begin
                inSr_reg <= 1'b0;
            end
            // New lock value before entry relocks at exit; after entry it needs MR0
            if (mr6Write && !inSr_reg) begin
                relockAtExit_reg <= 1'b1; // [R17]
            end else if (isSrx || mr6Write || resetStart) begin
                relockAtExit_reg <= 1'b0; // [R17]
            end
        end
    end

    // Violations seen by the device; set wins over clear
    logic parityBad;
    logic seqBad;
    logic latBad;
    assign parityBad = !dllEnable_reg && (parityLat_reg != 3'h0); // [R11]
    // Any command other than exit while in self refresh, or early commands other than MRS, SRE, SRX and ZQCL
    assign seqBad = (inSr_reg && cmdEvent && !isSrx)
                  || (isOther && (modBusy || srBusy || zqBusy)); // [R7]
    assign latBad = !dllEnable_reg
                  && ((readLatency != DLLM_DLL_OFF_READ_LATENCY)
                  || (writeLatency != DLLM_DLL_OFF_WRITE_LATENCY)); // [R10]

    // Strobe window start after READ, one cycle earlier with DLL off
    logic [DLLM_LAT_W:0] strobeNext;
    assign strobeNext = ({1'b0, additiveLatency} + {1'b0, readLatency})
                      - {{DLLM_LAT_W{1'b0}}, !dllEnable_reg}; // [R12]

    // Registered outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dllEnabled <= DLLM_DLL_ENABLE_RESET;
            dllLocked <= 1'b0;
            inSelfRefresh <= 1'b0;
            clockIgnored <= 1'b0;
            cmdReady <= 1'b0;
            lockedCmdReady <= 1'b0;
            strobeStartCycles <= '0;
            latencyUnsupported <= 1'b0;
            parityViolation <= 1'b0;
            sequenceViolation <= 1'b0;
        end else begin
            dllEnabled <= dllEnable_reg;
            dllLocked <= (dll_reg == DLLM_DLL_LOCKED);
            inSelfRefresh <= inSr_reg;
            clockIgnored <= inSr_reg && !srBusy; // [R14]
            cmdReady <= !inSr_reg && !modBusy && !srBusy && !zqBusy; // [R7]
            lockedCmdReady <= !inSr_reg && !modBusy && !srBusy && !zqBusy
                            && (dll_reg == DLLM_DLL_LOCKED); // [R7]
            strobeStartCycles <= strobeNext;
            latencyUnsupported <= latBad;
            if (parityBad) begin
                parityViolation <= 1'b1;
            end else if (errClear) begin
                parityViolation <= 1'b0;
            end
            if (seqBad) begin
                sequenceViolation <= 1'b1;
            end else if (errClear) begin
                sequenceViolation <= 1'b0;
            end
        end
    end

endmodule : dllm_dll_mode

// ### src/dllm_pkg.sv
package dllm_pkg;

    // Commands as decoded at the link
    typedef enum logic [2:0] {
        DLLM_CMD_NOP   = 3'h0,
        DLLM_CMD_MRS   = 3'h1,
        DLLM_CMD_SRE   = 3'h2,
        DLLM_CMD_SRX   = 3'h3,
        DLLM_CMD_READ  = 3'h4,
        DLLM_CMD_ZQCL  = 3'h5,
        DLLM_CMD_OTHER = 3'h6
    } dllm_cmd_type;

    // Delay-locked loop condition
    typedef enum logic [1:0] {
        DLLM_DLL_OFF        = 2'h0,
        DLLM_DLL_WAIT_RESET = 2'h1,
        DLLM_DLL_LOCKING    = 2'h2,
        DLLM_DLL_LOCKED     = 2'h3
    } dllm_dll_type;

    localparam int DLLM_MR_W = 18;
    localparam int DLLM_TIMER_W = 16;
    localparam int DLLM_LAT_W = 5;

    // Mode register indices
    localparam logic [2:0] DLLM_MR0 = 3'h0;
    localparam logic [2:0] DLLM_MR1 = 3'h1;
    localparam logic [2:0] DLLM_MR4 = 3'h4;
    localparam logic [2:0] DLLM_MR5 = 3'h5;
    localparam logic [2:0] DLLM_MR6 = 3'h6;

    // Field positions
    localparam int DLLM_MR1_DLL_ENABLE_BIT = 0;
    localparam int DLLM_MR0_DLL_RESET_BIT = 8;
    localparam int DLLM_MR4_SR_ABORT_BIT = 9;
    localparam int DLLM_MR5_PARITY_LSB = 0;
    localparam int DLLM_MR5_PARITY_MSB = 2;

    // Reset values
    localparam logic DLLM_DLL_ENABLE_RESET = 1'b1;
    localparam logic DLLM_SR_ABORT_RESET = 1'b0;
    localparam logic [2:0] DLLM_PARITY_RESET = 3'h0;

    // The only latency pair DLL-off mode must support
    localparam logic [DLLM_LAT_W-1:0] DLLM_DLL_OFF_READ_LATENCY = 5'h0A;
    localparam logic [DLLM_LAT_W-1:0] DLLM_DLL_OFF_WRITE_LATENCY = 5'h09;

    localparam logic [DLLM_TIMER_W-1:0] DLLM_TIMER_ONE = 16'h0001;

endpackage : dllm_pkg

// ### src/dllm_sync.sv
`timescale 1ns/10ps
module dllm_sync (
    // Destination clock
    input wire logic clk,
    input wire logic rst,
    // Level crossing in and out
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_reg;
    logic stage2_reg;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule : dllm_sync

// ### src/dllm_timer.sv
`timescale 1ns/10ps
module dllm_timer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Start pulse and cycle count
    input wire logic start,
    input wire logic [WIDTH-1:0] cycles,
    // Status
    output logic busy
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic running;

    assign running = (count_reg != '0);
    // A count of zero still costs one cycle
    assign count_next = start ? ((cycles == '0) ? {{(WIDTH-1){1'b0}}, 1'b1} : cycles)
                      : (running ? count_reg - {{(WIDTH-1){1'b0}}, 1'b1} : count_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign busy = running;
endmodule : dllm_timer

// ### dv/dllm_dll_mode_properties.sv
`timescale 1ns/10ps
module dllm_dll_mode_properties
    import dllm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Configuration
    input wire logic [dllm_pkg::DLLM_LAT_W-1:0] readLatency,
    input wire logic [dllm_pkg::DLLM_LAT_W-1:0] writeLatency,
    input wire logic [dllm_pkg::DLLM_LAT_W-1:0] additiveLatency,
    input wire logic [dllm_pkg::DLLM_TIMER_W-1:0] srEntryClockHold,
    input wire logic errClear,
    // Status
    input wire logic dllEnabled,
    input wire logic dllLocked,
    input wire logic inSelfRefresh,
    input wire logic clockIgnored,
    input wire logic cmdReady,
    input wire logic lockedCmdReady,
    input wire logic [dllm_pkg::DLLM_LAT_W:0] strobeStartCycles,
    input wire logic latencyUnsupported,
    input wire logic parityViolation
);
    logic [15:0] srCnt_reg;
    // Cycles spent in self refresh so far
    always_ff @(posedge ref_clk) begin
        if (rst || !inSelfRefresh)
            srCnt_reg <= 16'h0000;
        else
            srCnt_reg <= srCnt_reg + 16'h0001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_strobe_on;
        (!$past(rst) && dllEnabled && $stable(dllEnabled) && $stable(readLatency)
            && $stable(additiveLatency)) |-> strobeStartCycles == 6'(readLatency) + 6'(additiveLatency);
    endproperty
    a_strobe_on: assert property (p_strobe_on) else $error("Strobe start wrong with DLL on");
    property p_strobe_off;
        (!$past(rst) && !dllEnabled && $stable(dllEnabled) && $stable(readLatency)
            && $stable(additiveLatency))
            |-> strobeStartCycles == 6'(readLatency) + 6'(additiveLatency) - 6'h01;
    endproperty
    a_strobe_off: assert property (p_strobe_off) else $error("Strobe start wrong with DLL off");
    property p_latency;
        (!$past(rst) && $stable(dllEnabled) && $stable(readLatency) && $stable(writeLatency))
            |-> latencyUnsupported == (!dllEnabled && !(readLatency == 5'h0A && writeLatency == 5'h09));
    endproperty
    a_latency: assert property (p_latency) else $error("Latency pair flag wrong");
    property p_off_unlocked;
        (!dllEnabled && !$past(dllEnabled)) |-> !dllLocked;
    endproperty
    a_off_unlocked: assert property (p_off_unlocked) else $error("Locked while DLL off");
    property p_locked_ready;
        lockedCmdReady == (cmdReady && dllLocked);
    endproperty
    a_locked_ready: assert property (p_locked_ready) else $error("Locked ready mismatch");
    property p_sr_busy;
        (inSelfRefresh && $past(inSelfRefresh)) |-> !cmdReady;
    endproperty
    a_sr_busy: assert property (p_sr_busy) else $error("Ready inside self refresh");
    property p_ignore_in_sr;
        clockIgnored |-> inSelfRefresh;
    endproperty
    a_ignore_in_sr: assert property (p_ignore_in_sr) else $error("Clock ignored outside SR");
    property p_ignore_hold;
        $rose(clockIgnored) |-> srCnt_reg + 16'h0001 >= srEntryClockHold;
    endproperty
    a_ignore_hold: assert property (p_ignore_hold) else $error("Clock ignored too early");
    property p_parity_sticky;
        ($past(parityViolation) && !$past(errClear)) |-> parityViolation;
    endproperty
    a_parity_sticky: assert property (p_parity_sticky) else $error("Parity flag lost");
    property p_exit_wait;
        $fell(inSelfRefresh) |-> !cmdReady [*3];
    endproperty
    a_exit_wait: assert property (p_exit_wait) else $error("Ready too soon after exit");
endmodule : dllm_dll_mode_properties
bind dllm_dll_mode dllm_dll_mode_properties u_props (.ref_clk, .rst, .readLatency, .writeLatency,
    .additiveLatency, .srEntryClockHold, .errClear, .dllEnabled, .dllLocked, .inSelfRefresh,
    .clockIgnored, .cmdReady, .lockedCmdReady, .strobeStartCycles, .latencyUnsupported,
    .parityViolation);

// ### dv/dllm_ctl_model.sv
`timescale 1ns/10ps
module dllm_ctl_model
    import dllm_pkg::*;
(
    // Command clock and word
    output logic linkClk,
    output logic cmdValid,
    output dllm_pkg::dllm_cmd_type cmdCode,
    output logic [2:0] mrIndex,
    output logic [dllm_pkg::DLLM_MR_W-1:0] mrValue
);
    real halfPeriod = 80.0;
    logic clkStop = 1'b0;
    initial begin
        linkClk = 1'b0;
        cmdValid = 1'b0;
        cmdCode = DLLM_CMD_NOP;
        mrIndex = 3'h7;
        mrValue = 18'h2AAAA;
        #37;
        forever begin
            #(halfPeriod);
            // Stops low only, never mid-cycle high
            if (!clkStop || linkClk)
                linkClk = ~linkClk;
        end
    end
    // Idle gap first keeps command spacing legal
    task automatic send(input dllm_cmd_type code, input logic [2:0] idx, input logic [17:0] val);
        repeat (3) @(negedge linkClk);
        cmdValid = 1'b1;
        cmdCode = code;
        mrIndex = idx;
        mrValue = val;
        @(negedge linkClk);
        cmdValid = 1'b0;
        cmdCode = DLLM_CMD_NOP;
        mrIndex = ~idx;
        mrValue = ~val;
    endtask : send
    // Only called once the device ignores the clock
    task automatic set_clock(input real hp);
        clkStop = 1'b1;
        #500;
        halfPeriod = hp;
        clkStop = 1'b0;
        repeat (4) @(negedge linkClk);
    endtask : set_clock
endmodule : dllm_ctl_model

// ### dv/tb_dllm_dll_mode.sv
`timescale 1ns/10ps
module tb_dllm_dll_mode;
    import dllm_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic errClear = 1'b0;
    logic linkClk, cmdValid, dllEnabled, dllLocked, inSelfRefresh, clockIgnored, cmdReady;
    logic lockedCmdReady, latencyUnsupported, parityViolation, sequenceViolation;
    dllm_cmd_type cmdCode;
    logic [2:0] mrIndex;
    logic [DLLM_MR_W-1:0] mrValue;
    logic [DLLM_LAT_W-1:0] rl = 5'h0A, wl = 5'h09, al = 5'h00;
    logic [DLLM_TIMER_W-1:0] tHold = 16'h0006, tAbort = 16'h0005, mode_update_delay = 16'h0008;
    logic [DLLM_TIMER_W-1:0] tLock = 16'h0014, tExit = 16'h000E, tZq = 16'h0010;
    logic [DLLM_LAT_W:0] strobeStartCycles;
    int fail_count = 0;
    int cmp_count = 0;
    int n;
    always #25 ref_clk = ~ref_clk;
    dllm_ctl_model ctl (.linkClk, .cmdValid, .cmdCode, .mrIndex, .mrValue);
    dllm_dll_mode dut (.ref_clk, .rst, .linkClk, .cmdValid, .cmdCode, .mrIndex, .mrValue,
        .readLatency(rl), .writeLatency(wl), .additiveLatency(al), .srEntryClockHold(tHold),
        .srExitDelay(tExit), .srExitAbortDelay(tAbort), .modeUpdateDelay(mode_update_delay),
        .dllLockTime(tLock), .longCalibrationTime(tZq), .errClear, .dllEnabled, .dllLocked,
        .inSelfRefresh, .clockIgnored, .cmdReady, .lockedCmdReady, .strobeStartCycles,
        .latencyUnsupported, .parityViolation, .sequenceViolation);
    function automatic logic [5:0] exp_strobe(input logic en);
        return 6'(al) + 6'(rl) - (en ? 6'h00 : 6'h01);
    endfunction : exp_strobe
    function automatic logic exp_unsup(input logic en);
        return !en && !(rl == 5'h0A && wl == 5'h09);
    endfunction : exp_unsup
    task automatic tally_and_finish();
        $display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_min(input int got, input int lo);
        cmp_count++;
        if (got < lo) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h min=%h", $time, got, lo);
        end
    endtask : chk_min
    // Cycles until ready, locked or clock ignored
    task automatic wait_for(input int sel, output int cyc);
        cyc = 0;
        do begin
            @(negedge ref_clk);
            cyc++;
            if (cyc > 400) begin
                fail_count++;
                tally_and_finish();
            end
        end while (sel == 0 ? cmdReady !== 1'b1 : sel == 1 ? dllLocked !== 1'b1 : clockIgnored !== 1'b1);
    endtask : wait_for
    // Values are taken after the wait, so a flag is seen once it has settled
    task automatic settle();
        repeat (4) @(negedge ref_clk);
    endtask : settle
    initial begin
        n = $urandom(18653);
        @(negedge ref_clk);
        tExit = 16'(14 + $urandom_range(6));
        tZq = 16'(8 + $urandom_range(12));
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        chk(dllEnabled, 1'b1);
        chk(dllLocked, 1'b0);
        ctl.send(DLLM_CMD_MRS, DLLM_MR0, 18'h00100);
        wait_for(1, n);
        chk_min(n, tLock);
        wait_for(0, n);
        chk(lockedCmdReady, 1'b1);
        for (int i = 0; i < 4; i++) begin
            rl = 5'(9 + $urandom_range(7));
            al = 5'($urandom_range(3));
            repeat (4) @(negedge ref_clk);
            chk(strobeStartCycles, exp_strobe(1'b1));
            chk(latencyUnsupported, 1'b0);
        end
        rl = 5'h0A;
        al = 5'h00;
        ctl.send(DLLM_CMD_MRS, DLLM_MR1, 18'h00000);
        repeat (4) @(negedge ref_clk);
        chk(dllEnabled, 1'b0);
        chk(dllLocked, 1'b0);
        chk(strobeStartCycles, exp_strobe(1'b0));
        chk(latencyUnsupported, exp_unsup(1'b0));
        rl = 5'h0B;
        settle();
        chk(latencyUnsupported, exp_unsup(1'b0));
        rl = 5'h0A;
        ctl.send(DLLM_CMD_MRS, DLLM_MR5, 18'h00004);
        settle();
        chk(parityViolation, 1'b1);
        ctl.send(DLLM_CMD_MRS, DLLM_MR5, 18'h00000);
        @(negedge ref_clk);
        errClear = 1'b1;
        settle();
        chk(parityViolation, 1'b0);
        errClear = 1'b0;
        ctl.send(DLLM_CMD_SRE, 3'h0, 18'h00000);
        wait_for(2, n);
        chk_min(n, tHold);
        chk(cmdReady, 1'b0);
        ctl.set_clock(100.0);
        ctl.send(DLLM_CMD_SRX, 3'h0, 18'h00000);
        wait_for(0, n);
        chk_min(n, tExit - 1);
        chk(inSelfRefresh, 1'b0);
        ctl.send(DLLM_CMD_MRS, DLLM_MR1, 18'h00001);
        ctl.send(DLLM_CMD_MRS, DLLM_MR0, 18'h00100);
        wait_for(1, n);
        chk_min(n, tLock);
        ctl.send(DLLM_CMD_MRS, DLLM_MR4, 18'h00200);
        ctl.send(DLLM_CMD_MRS, DLLM_MR6, 18'h00015);
        ctl.send(DLLM_CMD_SRE, 3'h0, 18'h00000);
        wait_for(2, n);
        ctl.send(DLLM_CMD_READ, 3'h0, 18'h00000);
        settle();
        chk(sequenceViolation, 1'b1);
        ctl.set_clock(80.0);
        ctl.send(DLLM_CMD_SRX, 3'h0, 18'h00000);
        wait_for(0, n);
        chk_min(n, tAbort - 1);
        chk_min(tExit, n);
        chk(dllLocked, 1'b0);
        wait_for(1, n);
        chk(dllLocked, 1'b1);
        ctl.send(DLLM_CMD_ZQCL, 3'h0, 18'h00000);
        settle();
        chk(cmdReady, 1'b0);
        wait_for(0, n);
        chk_min(n + 4, tZq - 1);
        tally_and_finish();
    end
endmodule : tb_dllm_dll_mode
